/* design/pwk_pkg.sv */
package pwk_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 25_000_000;  // ref_clk rate
  localparam int unsigned DBL_CLICK_MS  = 500;         // double-click window, ms
  localparam int unsigned DBL_CLICK_CYC = DBL_CLICK_MS * (CLK_HZ / 1000);
  localparam int unsigned FRAME_TMO_US  = 2000;        // stalled frame abort, us
  localparam int unsigned FRAME_TMO_CYC = FRAME_TMO_US * (CLK_HZ / 1_000_000);
  localparam int          DBL_W         = 24;          // window counter width
  localparam int          TMO_W         = 16;          // frame timeout width

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          AW            = 5;
  localparam int          DW            = 8;
  localparam logic [4:0]  OFS_KBD_CTL   = 5'h04;       // kbd_wake_control
  localparam logic [4:0]  OFS_PROTO     = 5'h05;       // ps2_wake_protocol_control
  localparam logic [4:0]  OFS_KDATA     = 5'h06;       // last keyboard byte
  localparam logic [4:0]  OFS_MDATA     = 5'h07;       // last mouse buttons
  localparam logic [4:0]  OFS_KEY_FIRST = 5'h08;       // key_match_byte_0
  localparam logic [4:0]  OFS_KEY_LAST  = 5'h0F;       // key_match_byte_7
  localparam logic [4:0]  OFS_STATUS    = 5'h10;       // sticky events, w1c
  localparam logic [4:0]  OFS_MASK      = 5'h11;       // interrupt mask
  localparam logic [7:0]  RST_KBD_CTL   = 8'h40;
  localparam logic [7:0]  RST_PROTO     = 8'h10;
  localparam int          KEY_N         = 8;
  localparam int          KEY_IW        = 3;
  localparam logic [2:0]  EV1_BASE      = 3'h0;        // first byte of event 1
  localparam logic [2:0]  EV2_BASE      = 3'h3;        // first byte of event 2
  localparam logic [7:0]  KEY_WILDCARD  = 8'h00;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int          KMODE_HI      = 7;
  localparam int          KMODE_LO      = 6;
  localparam int          EV2_HI        = 3;
  localparam int          EV2_LO        = 2;
  localparam int          EV1_HI        = 1;
  localparam int          EV1_LO        = 0;
  localparam int          PAR_OFF_BIT   = 7;
  localparam int          MSEL_HI       = 6;
  localparam int          MSEL_LO       = 4;
  localparam logic [1:0]  KMODE_SEQ     = 2'h0;        // special sequence / password
  localparam logic [1:0]  KMODE_ANY     = 2'h1;        // fast any-key
  localparam logic [1:0]  KMODE_PM      = 2'h2;        // power-management keys
  localparam logic [1:0]  LEN_OFF       = 2'h0;
  localparam logic [2:0]  MSEL_OFF      = 3'h0;
  localparam logic [2:0]  MSEL_ANY      = 3'h1;
  localparam logic [2:0]  MSEL_LCLK     = 3'h2;
  localparam logic [2:0]  MSEL_LDBL     = 3'h3;
  localparam logic [2:0]  MSEL_RCLK     = 3'h4;
  localparam logic [2:0]  MSEL_RDBL     = 3'h5;
  localparam logic [2:0]  MSEL_ACLK     = 3'h6;
  localparam logic [2:0]  MSEL_ADBL     = 3'h7;
  localparam logic [2:0]  BTN_L         = 3'h1;
  localparam logic [2:0]  BTN_R         = 3'h2;
  localparam logic [2:0]  BTN_ALL       = 3'h7;
  localparam int          MS_SYNC_BIT   = 3;           // always set in a mouse byte 0
  localparam int          ST_EV1        = 0;
  localparam int          ST_EV2        = 1;
  localparam int          ST_ANYKEY     = 2;
  localparam int          ST_MOUSE      = 3;
  localparam int          ST_PERR       = 4;
  localparam int          ST_W          = 5;
  localparam logic [3:0]  FRAME_LAST    = 4'hA;        // stop bit index

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } pwk_bus_type;

  typedef struct packed {
    logic clk;
    logic dat;
  } pwk_ps2_type;

  typedef struct packed {
    logic [3:0]       cnt;   // bit position in frame
    logic [10:0]      sh;    // frame shifter, lsb first
    logic [TMO_W-1:0] tmo;   // idle cycles inside a frame
    logic             done;  // one-cycle good byte
    logic             perr;  // one-cycle parity fault
    logic [7:0]       data;
  } pwk_rx_type;

  typedef enum logic [2:0] {
    MS_B0 = 3'b001,
    MS_B1 = 3'b010,
    MS_B2 = 3'b100
  } pwk_ms_phase_type;

endpackage

/* design/pwk_keymem.sv */
module pwk_keymem (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // software write
  input  wire logic                         wr_en,
  input  wire logic [pwk_pkg::KEY_IW-1:0]   wr_idx,
  input  wire logic [7:0]                   wr_data,
  // matcher reads
  input  wire logic [pwk_pkg::KEY_IW-1:0]   ev1_idx,
  input  wire logic [pwk_pkg::KEY_IW-1:0]   ev2_idx,
  output logic      [7:0]                   ev1_q,
  output logic      [7:0]                   ev2_q,
  // software read, merged with the other registers
  input  wire logic                         rd_en,
  input  wire logic                         rd_is_key,
  input  wire logic [pwk_pkg::KEY_IW-1:0]   rd_idx,
  input  wire logic [7:0]                   ext_data,
  output logic      [7:0]                   rd_q
);

  typedef struct packed {
    logic [pwk_pkg::KEY_N-1:0][7:0] key;   // key match bytes
    logic [7:0]                     ev1;
    logic [7:0]                     ev2;
    logic [7:0]                     rd;
  } pwk_mem_type;

  pwk_mem_type s;       // state
  pwk_mem_type next_s;  // next state

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_s = s;
    if (wr_en) begin
      next_s.key[wr_idx] = wr_data;
    end
    next_s.ev1 = s.key[ev1_idx];
    next_s.ev2 = s.key[ev2_idx];
    // read data only in the cycle after the strobe
    if (rd_en) begin
      next_s.rd = rd_is_key ? s.key[rd_idx] : ext_data;
    end else begin
      next_s.rd = '0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ev1_q = s.ev1;
  assign ev2_q = s.ev2;
  assign rd_q  = s.rd;

endmodule

/* design/pwk_top.sv */
module pwk_top #(
  parameter int unsigned DBL_CLICK_CYCLES = pwk_pkg::DBL_CLICK_CYC,
  parameter int unsigned FRAME_TMO_CYCLES = pwk_pkg::FRAME_TMO_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // register port
  input  wire pwk_pkg::pwk_bus_type  bus,
  output logic [pwk_pkg::DW-1:0]     rd_data,
  // snooped ps/2 lines
  input  wire pwk_pkg::pwk_ps2_type  kbd_link,
  input  wire pwk_pkg::pwk_ps2_type  mouse_link,
  // wake events, one-cycle pulses
  output logic                       kbd_event1,
  output logic                       kbd_event2,
  output logic                       any_key_event,
  output logic                       mouse_event,
  // interrupt, level
  output logic                       irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]                  ksy_c;     // keyboard clock synchroniser
    logic [1:0]                  ksy_d;     // keyboard data synchroniser
    logic [1:0]                  msy_c;     // mouse clock synchroniser
    logic [1:0]                  msy_d;     // mouse data synchroniser
    logic                        k_last;    // keyboard clock, previous sample
    logic                        m_last;    // mouse clock, previous sample
    pwk_pkg::pwk_rx_type         krx;       // keyboard receiver
    pwk_pkg::pwk_rx_type         mrx;       // mouse receiver
    logic [7:0]                  kbd_ctl;   // kbd_wake_control
    logic [7:0]                  proto;     // ps2_wake_protocol_control
    logic [7:0]                  kdata;     // last good keyboard byte
    logic [2:0]                  mdata;     // last mouse button state
    logic [1:0]                  p1;        // event 1 progress
    logic [1:0]                  p2;        // event 2 progress
    pwk_pkg::pwk_ms_phase_type   ph;        // mouse packet phase
    logic [2:0]                  btn_prev;  // buttons of previous packet
    logic                        armed;     // first click of a double seen
    logic [pwk_pkg::DBL_W-1:0]   dbl_cnt;   // double-click window left
    logic [pwk_pkg::ST_W-1:0]    status;    // sticky events
    logic [pwk_pkg::ST_W-1:0]    mask;      // interrupt enables
    logic                        irq;
    logic                        ev1;
    logic                        ev2;
    logic                        anyk;
    logic                        mev;
  } pwk_top_type;

  pwk_top_type s;       // state
  pwk_top_type next_s;  // next state

  localparam logic [pwk_pkg::TMO_W-1:0] TMO_LIM = pwk_pkg::TMO_W'(FRAME_TMO_CYCLES);
  localparam logic [pwk_pkg::DBL_W-1:0] DBL_LIM = pwk_pkg::DBL_W'(DBL_CLICK_CYCLES);

  // ************************************************************
  // functions
  // ************************************************************
  // one ref_clk step of a frame receiver
  function automatic pwk_pkg::pwk_rx_type rx_step(pwk_pkg::pwk_rx_type r,
                                                  logic fall, logic dat, logic par_off);
    pwk_pkg::pwk_rx_type n;
    logic                par_ok;
    n      = r;
    n.done = 1'b0;
    n.perr = 1'b0;
    par_ok = 1'b0;
    if (fall) begin
      n.sh  = {dat, r.sh[10:1]};
      n.tmo = '0;
      if (r.cnt == pwk_pkg::FRAME_LAST) begin
        n.cnt = '0;
        // start low, stop high, else the frame is dropped silently
        if (!n.sh[0] && n.sh[10]) begin
          par_ok = ^n.sh[9:1];                    // odd parity
          n.done = par_off | par_ok;
          n.perr = ~par_off & ~par_ok;
          n.data = n.sh[8:1];
        end
      end else begin
        n.cnt = r.cnt + 4'h1;
      end
    end else if (r.cnt != '0) begin
      // a stalled frame would misalign every later byte
      if (r.tmo == TMO_LIM) begin
        n.cnt = '0;
        n.tmo = '0;
      end else begin
        n.tmo = r.tmo + 1'b1;
      end
    end
    return n;
  endfunction

  // sequence compare: returns {hit, next progress}
  function automatic logic [2:0] seq_step(logic [1:0] p, logic [1:0] len,
                                          logic [7:0] exp, logic [7:0] b);
    logic [1:0] p_inc;
    p_inc = p + 2'h1;
    if (exp == pwk_pkg::KEY_WILDCARD || exp == b) begin
      if (p_inc == len) begin
        seq_step = {1'b1, 2'h0};
      end else begin
        seq_step = {1'b0, p_inc};
      end
    end else begin
      seq_step = {1'b0, 2'h0};
    end
  endfunction

  // ************************************************************
  // key byte memory and read path
  // ************************************************************
  logic [7:0]                  ev1_exp;   // expected byte for event 1
  logic [7:0]                  ev2_exp;   // expected byte for event 2
  logic [7:0]                  ext_data;  // non-memory read value
  logic                        key_hit;   // address in key window
  logic [pwk_pkg::KEY_IW-1:0]  ev1_idx;
  logic [pwk_pkg::KEY_IW-1:0]  ev2_idx;
  logic [pwk_pkg::KEY_IW-1:0]  bus_idx;

  assign key_hit = (bus.addr >= pwk_pkg::OFS_KEY_FIRST) && (bus.addr <= pwk_pkg::OFS_KEY_LAST);
  assign bus_idx = bus.addr[pwk_pkg::KEY_IW-1:0];
  // progress walks from the event's first byte upward
  assign ev1_idx = pwk_pkg::EV1_BASE + {1'b0, s.p1};
  assign ev2_idx = pwk_pkg::EV2_BASE + {1'b0, s.p2};

  // register read mux, unmapped addresses read zero
  always_comb begin
    ext_data = '0;
    unique case (bus.addr)
      pwk_pkg::OFS_KBD_CTL: ext_data = s.kbd_ctl;
      pwk_pkg::OFS_PROTO:   ext_data = s.proto;
      pwk_pkg::OFS_KDATA:   ext_data = s.kdata;
      pwk_pkg::OFS_MDATA:   ext_data = {5'h00, s.mdata};
      pwk_pkg::OFS_STATUS:  ext_data = {3'h0, s.status};
      pwk_pkg::OFS_MASK:    ext_data = {3'h0, s.mask};
      default:              ext_data = '0;
    endcase
  end

  pwk_keymem u_keymem (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .wr_en     (bus.wr && key_hit),
    .wr_idx    (bus_idx),
    .wr_data   (bus.wdata),
    .ev1_idx   (ev1_idx),
    .ev2_idx   (ev2_idx),
    .ev1_q     (ev1_exp),
    .ev2_q     (ev2_exp),
    .rd_en     (bus.rd),
    .rd_is_key (key_hit),
    .rd_idx    (bus_idx),
    .ext_data  (ext_data),
    .rd_q      (rd_data)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [2:0]               r1;       // event 1 compare result
    logic [2:0]               r2;       // event 2 compare result
    logic [2:0]               press;    // buttons newly down
    logic [2:0]               qual;     // buttons the select watches
    logic                     dbl;      // select wants double-click
    logic [7:0]               b;        // received byte
    logic [pwk_pkg::ST_W-1:0] set;      // events this cycle
    logic [pwk_pkg::ST_W-1:0] clr;      // software clear
    logic [2:0]               msel;
    r1     = '0;
    r2     = '0;
    press  = '0;
    qual   = '0;
    dbl    = 1'b0;
    b      = '0;
    set    = '0;
    clr    = '0;
    msel   = s.proto[pwk_pkg::MSEL_HI:pwk_pkg::MSEL_LO];
    next_s = s;
    next_s.ev1  = 1'b0;
    next_s.ev2  = 1'b0;
    next_s.anyk = 1'b0;
    next_s.mev  = 1'b0;

    // synchronisers, only the second stage (bit 1) is looked at
    next_s.ksy_c  = {s.ksy_c[0], kbd_link.clk};
    next_s.ksy_d  = {s.ksy_d[0], kbd_link.dat};
    next_s.msy_c  = {s.msy_c[0], mouse_link.clk};
    next_s.msy_d  = {s.msy_d[0], mouse_link.dat};
    next_s.k_last = s.ksy_c[1];
    next_s.m_last = s.msy_c[1];

    // receivers sample data on the falling link clock
    next_s.krx = rx_step(s.krx, s.k_last & ~s.ksy_c[1], s.ksy_d[1],
                         s.proto[pwk_pkg::PAR_OFF_BIT]);
    next_s.mrx = rx_step(s.mrx, s.m_last & ~s.msy_c[1], s.msy_d[1],
                         s.proto[pwk_pkg::PAR_OFF_BIT]);
    set[pwk_pkg::ST_PERR] = next_s.krx.perr | next_s.mrx.perr;

    // keyboard byte, only good bytes reach the matchers
    if (s.krx.done) begin
      b            = s.krx.data;
      next_s.kdata = b;
      unique case (s.kbd_ctl[pwk_pkg::KMODE_HI:pwk_pkg::KMODE_LO])
        pwk_pkg::KMODE_ANY: begin
          next_s.anyk = 1'b1;
        end
        pwk_pkg::KMODE_PM: begin
          if (s.kbd_ctl[pwk_pkg::EV1_HI:pwk_pkg::EV1_LO] != pwk_pkg::LEN_OFF) begin
            r1 = seq_step(s.p1, s.kbd_ctl[pwk_pkg::EV1_HI:pwk_pkg::EV1_LO],
                          ev1_exp, b);
            next_s.p1  = r1[1:0];
            next_s.ev1 = r1[2];
          end
          if (s.kbd_ctl[pwk_pkg::EV2_HI:pwk_pkg::EV2_LO] != pwk_pkg::LEN_OFF) begin
            r2 = seq_step(s.p2, s.kbd_ctl[pwk_pkg::EV2_HI:pwk_pkg::EV2_LO],
                          ev2_exp, b);
            next_s.p2  = r2[1:0];
            next_s.ev2 = r2[2];
          end
        end
        default: begin
          // sequence mode is not handled and raises no event, reserved code is idle
        end
      endcase
    end

    // double-click window runs down
    if (s.armed) begin
      if (s.dbl_cnt == '0) begin
        next_s.armed = 1'b0;
      end else begin
        next_s.dbl_cnt = s.dbl_cnt - 1'b1;
      end
    end

    // mouse trigger decode
    unique case (msel)
      pwk_pkg::MSEL_LCLK, pwk_pkg::MSEL_LDBL: qual = pwk_pkg::BTN_L;
      pwk_pkg::MSEL_RCLK, pwk_pkg::MSEL_RDBL: qual = pwk_pkg::BTN_R;
      pwk_pkg::MSEL_ACLK, pwk_pkg::MSEL_ADBL: qual = pwk_pkg::BTN_ALL;
      default:                                qual = '0;
    endcase
    dbl = (msel == pwk_pkg::MSEL_LDBL) || (msel == pwk_pkg::MSEL_RDBL) ||
          (msel == pwk_pkg::MSEL_ADBL);

    // mouse byte, packet phase tracks the three-byte packet
    if (s.mrx.done) begin
      b = s.mrx.data;
      if (msel == pwk_pkg::MSEL_ANY) begin
        next_s.mev = 1'b1;
      end
      unique case (s.ph)
        pwk_pkg::MS_B0: begin
          // without the sync bit the byte is not a packet head
          if (b[pwk_pkg::MS_SYNC_BIT]) begin
            next_s.ph       = pwk_pkg::MS_B1;
            next_s.mdata    = b[2:0];
            next_s.btn_prev = b[2:0];
            press           = b[2:0] & ~s.btn_prev;
            if ((press & qual) != '0) begin
              if (!dbl) begin
                next_s.mev = 1'b1;
              end else if (s.armed) begin
                next_s.mev   = 1'b1;
                next_s.armed = 1'b0;
              end else begin
                next_s.armed   = 1'b1;
                next_s.dbl_cnt = DBL_LIM;
              end
            end
          end
        end
        pwk_pkg::MS_B1: next_s.ph = pwk_pkg::MS_B2;
        pwk_pkg::MS_B2: next_s.ph = pwk_pkg::MS_B0;
        default:        next_s.ph = pwk_pkg::MS_B0;
      endcase
    end

    // software writes
    if (bus.wr) begin
      unique case (bus.addr)
        pwk_pkg::OFS_KBD_CTL: begin
          next_s.kbd_ctl = bus.wdata;
          next_s.p1      = '0;
          next_s.p2      = '0;
        end
        pwk_pkg::OFS_PROTO: begin
          next_s.proto = bus.wdata;
          // a new trigger starts from a clean click history
          next_s.armed = 1'b0;
        end
        pwk_pkg::OFS_STATUS: clr = bus.wdata[pwk_pkg::ST_W-1:0];
        pwk_pkg::OFS_MASK:   next_s.mask = bus.wdata[pwk_pkg::ST_W-1:0];
        default: begin
          // key bytes are written in pwk_keymem, others read-only or unmapped, write ignored
        end
      endcase
    end

    // sticky status, a new event beats a clear in the same cycle
    set[pwk_pkg::ST_EV1]    = next_s.ev1;
    set[pwk_pkg::ST_EV2]    = next_s.ev2;
    set[pwk_pkg::ST_ANYKEY] = next_s.anyk;
    set[pwk_pkg::ST_MOUSE]  = next_s.mev;
    next_s.status = (s.status & ~clr) | set;
    next_s.irq    = |(next_s.status & next_s.mask);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s         <= '0;
      s.kbd_ctl <= pwk_pkg::RST_KBD_CTL;
      s.proto   <= pwk_pkg::RST_PROTO;
      s.ph      <= pwk_pkg::MS_B0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign kbd_event1    = s.ev1;
  assign kbd_event2    = s.ev2;
  assign any_key_event = s.anyk;
  assign mouse_event   = s.mev;
  assign irq           = s.irq;

endmodule

/* dv/pwk_ps2_dev.sv */
module pwk_ps2_dev (
  // link toward the snooper
  output pwk_pkg::pwk_ps2_type link
);
  timeunit 1ns;
  timeprecision 1ps;
  initial link = 2'b11;  // both lines pulled high when idle
  // one frame: start, lsb first, odd parity (bad flips it), stop
  task send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    #10;  // keep link edges off the ref_clk sampling edges
    for (int i = 0; i < 11; i++) begin
      link.dat = f[i];
      #80 link.clk = 1'b0;
      #160 link.clk = 1'b1;
      #80;
    end
    link.dat = 1'b1;  // released data returns to the pull-up
  endtask
endmodule

/* dv/pwk_top_sva.sv */
module pwk_top_sva #(
  parameter int unsigned DBL_CLICK_CYCLES = 2000,
  parameter int unsigned FRAME_TMO_CYCLES = 500
) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  // register port
  input wire pwk_pkg::pwk_bus_type bus,
  input wire logic [7:0]           rd_data,
  // links
  input wire pwk_pkg::pwk_ps2_type kbd_link,
  input wire pwk_pkg::pwk_ps2_type mouse_link,
  // events
  input wire logic                 kbd_event1,
  input wire logic                 kbd_event2,
  input wire logic                 any_key_event,
  input wire logic                 mouse_event,
  input wire logic                 irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] kctl;   // shadow of kbd_wake_control
  logic [7:0] proto;  // shadow of protocol control
  logic [4:0] msk;    // shadow of mask, a parity fault raises irq with no pulse
  // shadows follow software writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      kctl  <= 8'h40;
      proto <= 8'h10;
      msk   <= 5'h00;
    end else if (bus.wr && bus.addr == 5'h04) begin
      kctl  <= bus.wdata;
    end else if (bus.wr && bus.addr == 5'h05) begin
      proto <= bus.wdata;
    end else if (bus.wr && bus.addr == 5'h11) begin
      msk   <= bus.wdata[4:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  rd_idle_a: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
    else $error("read data not idle");
  proto_rdbk_a: assert property (bus.rd && bus.addr == 5'h05 |=> rd_data == proto)
    else $error("protocol control readback wrong");
  ev1_mode_a: assert property (kbd_event1 |-> kctl[7:6] == 2'h2 && kctl[1:0] != 2'h0)
    else $error("event 1 outside its mode");
  ev2_mode_a: assert property (kbd_event2 |-> kctl[7:6] == 2'h2 && kctl[3:2] != 2'h0)
    else $error("event 2 outside its mode");
  anykey_mode_a: assert property (any_key_event |-> kctl[7:6] == 2'h1)
    else $error("any-key event outside its mode");
  mouse_off_a: assert property (mouse_event |-> proto[6:4] != 3'h0)
    else $error("mouse event while disabled");
  ev_pulse_a: assert property (kbd_event1 || kbd_event2 |=> !kbd_event1 && !kbd_event2)
    else $error("key event longer than a cycle");
  irq_cause_a: assert property ($rose(irq) && !$past(bus.wr) && !$past(bus.wr, 2) && !msk[4]
    |-> kbd_event1 || kbd_event2 || any_key_event || mouse_event)
    else $error("interrupt rose without an event");
  cover property (kbd_event1);
  cover property (kbd_event2);
  cover property (mouse_event);
endmodule

bind pwk_top pwk_top_sva #(.DBL_CLICK_CYCLES(DBL_CLICK_CYCLES),
  .FRAME_TMO_CYCLES(FRAME_TMO_CYCLES)) chk (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
  .rd_data(rd_data), .kbd_link(kbd_link), .mouse_link(mouse_link), .kbd_event1(kbd_event1),
  .kbd_event2(kbd_event2), .any_key_event(any_key_event), .mouse_event(mouse_event), .irq(irq));

/* dv/test_pwk_top.sv */
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_pwk_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk = 1'b0;
  logic                 resetn = 1'b0;
  pwk_pkg::pwk_bus_type bus = '0;
  pwk_pkg::pwk_ps2_type kl, ml;
  logic [7:0]           rd_data, r, x;
  logic                 e1, e2, ak, me, irq, rq = 1'b0;
  logic [7:0]           rdq[$];  // notes of read data
  logic [3:0]           evq[$];  // notes of event pulses {e1,e2,ak,me}
  logic [3:0]           y;
  int                   errors = 0, checked = 0, seed = 32'h57454D11, n;
  always #20 ref_clk = ~ref_clk;
  pwk_top #(.DBL_CLICK_CYCLES(2000), .FRAME_TMO_CYCLES(500)) uut (.ref_clk(ref_clk),
    .resetn(resetn), .bus(bus), .rd_data(rd_data), .kbd_link(kl), .mouse_link(ml),
    .kbd_event1(e1), .kbd_event2(e2), .any_key_event(ak), .mouse_event(me), .irq(irq));
  pwk_ps2_dev kbd (.link(kl));
  pwk_ps2_dev mouse (.link(ml));
  // watcher: each result takes the oldest note; a pulse with no note is compared to none
  always @(posedge ref_clk) begin
    if (rq) begin
      x = rdq.pop_front();
      `CHK("rd_data", x, rd_data)
    end
    if ({e1, e2, ak, me} !== 4'h0) begin
      y = evq.size() ? evq.pop_front() : 4'h0;
      `CHK("events", y, {e1, e2, ak, me})
    end
    rq = bus.rd;
  end
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge ref_clk);
    bus.wr    <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    rdq.push_back(e);
    @(posedge ref_clk);
    bus.rd   <= 1'b0;
  endtask
  // one byte on a link, then a bounded wait for the noted pulse
  task tx(input logic m, input logic [7:0] b, input logic bad, input logic [3:0] e);
    if (e != 4'h0) evq.push_back(e);
    if (m) mouse.send(b, bad);
    else kbd.send(b, bad);
    n = 0;
    repeat (12) @(posedge ref_clk);
    while (evq.size() != 0 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    if (evq.size() != 0) begin
      errors++;
      print_verdict();
    end
  endtask
  task chk_irq(input logic e);
    repeat (3) @(posedge ref_clk);
    #1 `CHK("irq", e, irq)
  endtask
  task print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(5'h05, 8'h10);
    rd(5'h04, 8'h40);
    rd(5'h1F, 8'h00);
    r = $random(seed);
    wr(5'h05, 8'h00);
    wr(5'h05, r);
    rd(5'h05, r);
    for (int i = 7; i >= 0; i--) begin
      wr(5'h05, 8'h00);
      wr(5'h05, 8'(i << 4));
      rd(5'h05, 8'(i << 4));
    end
    tx(1, 8'h08, 0, 4'h0);
    wr(5'h05, 8'h10);
    tx(1, 8'h08, 0, 4'h1);
    $display("test registers and mouse done");
    wr(5'h10, 8'h1F);
    wr(5'h11, 8'h1F);
    wr(5'h08, 8'h5E);
    wr(5'h09, 8'h00);
    wr(5'h0A, 8'h37);
    wr(5'h04, 8'h83);
    r = $random(seed);
    tx(0, 8'h5E, 0, 4'h0);
    tx(0, r, 0, 4'h0);
    tx(0, 8'h37, 0, 4'h8);
    chk_irq(1'b1);
    rd(5'h10, 8'h01);
    wr(5'h10, 8'h01);
    chk_irq(1'b0);
    tx(0, 8'h5E, 0, 4'h0);
    tx(0, r, 0, 4'h0);
    tx(0, 8'h38, 0, 4'h0);
    tx(0, 8'h5E, 0, 4'h0);
    tx(0, r, 0, 4'h0);
    tx(0, 8'h37, 0, 4'h8);
    wr(5'h10, 8'h1F);
    wr(5'h11, 8'h0F);
    tx(0, 8'h5E, 0, 4'h0);
    tx(0, r, 0, 4'h0);
    tx(0, 8'h37, 1, 4'h0);
    rd(5'h10, 8'h10);
    chk_irq(1'b0);
    $display("test event 1 done");
    wr(5'h0B, 8'hA1);
    wr(5'h0C, 8'hB2);
    wr(5'h0D, 8'hC3);
    for (int i = 1; i < 4; i++) begin
      wr(5'h04, 8'(8'h80 | (i << 2)));
      for (int j = 0; j < i; j++) tx(0, 8'hA1 + 8'(j * 17), 0, (j == i - 1) ? 4'h4 : 4'h0);
    end
    $display("test event 2 done");
    wr(5'h04, 8'h41);
    tx(0, 8'h5E, 0, 4'h2);
    wr(5'h04, 8'h01);
    tx(0, 8'h5E, 0, 4'h0);
    wr(5'h04, 8'h40);
    wr(5'h05, 8'h90);
    tx(0, 8'h5E, 1, 4'h2);
    wr(5'h05, 8'h10);
    tx(0, 8'h5E, 1, 4'h0);
    $display("test modes and parity done");
    wr(5'h05, 8'h00);
    wr(5'h05, 8'h30);
    // filler closes the open packet, then left press, release, press
    for (int k = 0; k < 8; k++) tx(1, (k % 3 != 1) ? 8'h00 : (k == 4) ? 8'h08 : 8'h09, 0,
      (k == 7) ? 4'h1 : 4'h0);
    $display("test mouse double-click done");
    print_verdict();
  end
endmodule
